// [bench/gcs_poller_model.sv]
// gcs_poller_model: apb master standing for the polling supervisor
// assumes pready, prdata and pslverr come straight from the status map
`timescale 1ns/1ps
`default_nettype none
module gcs_poller_model (
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic [31:0] prdata_i,
  input  wire logic        pslverr_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [15:0]      paddr_o,
  output logic [31:0]      pwdata_o
);
  initial begin
    psel_o    = 1'b0;
    penable_o = 1'b0;
    pwrite_o  = 1'b0;
    paddr_o   = 16'h0000;
    pwdata_o  = 32'h0000_0000;
  end

  // one transfer; request held until pready is seen at a rising edge, or released as hung after 50 more edges without it
  // words returned as raw integers, scaling left to the caller
  task automatic xfer(input  logic        wr,
                      input  logic [11:0] idx,
                      input  logic [31:0] wd,
                      output logic [31:0] rd,
                      output logic        err,
                      output logic        hung);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_o    <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o  <= wr;
    paddr_o   <= {2'b00, idx, 2'b00};
    pwdata_o  <= wd;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    rd        = prdata_i;
    err       = pslverr_i;
    hung      = (n >= 50);
    psel_o    <= 1'b0;
    penable_o <= 1'b0;
    // released value differs from what was driven, not a stale copy
    pwdata_o  <= ~wd;
  endtask : xfer

  // mismatch of the read checksum asks for a fresh upload
  task automatic cks_check(input  logic [31:0] expected,
                           input  logic [31:0] seen,
                           output logic        reupload);
    reupload = (seen !== expected);
  endtask : cks_check
endmodule : gcs_poller_model
`default_nettype wire

// [bench/test_gas_channel_status_map.sv]
// test_gas_channel_status_map: directed apb tests of the status map
// assumes gcs_pkg and the poller model are compiled beforehand
`timescale 1ns/1ps
`default_nettype none
module test_gas_channel_status_map;
  import gcs_pkg::*;
  // short second keeps the timing scenarios inside a brief run
  localparam int unsigned SEC_CYC = 20;
  logic          clk_i     = 1'b0;
  logic          rst_n_i   = 1'b0;
  logic          psel, penable, pwrite, pready, pslverr;
  logic [15:0]   paddr;
  logic [31:0]   pwdata, prdata, rd, s0;
  logic          upd_valid = 1'b0;
  gcs_chan_upd_s upd       = '0;
  logic          cfg_valid = 1'b0;
  gcs_cfg_byte_s cfg       = '0;
  logic          frame_ok  = 1'b0;
  logic          link_up   = 1'b1;
  logic          int_err   = 1'b0;
  logic          pwr_loss  = 1'b0;
  logic          alarm_sig, fault_closed, safe, stab, irq, err, hung, need;
  logic [2:0]    relay;
  logic [5:0]    fcnt      = 6'h00;
  logic [31:0]   fexp [4]  = '{32'h0, 32'h50, 32'h0, 32'h80};
  int            n_errors  = 0;
  int            cmp_count = 0;

  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    fcnt     <= fcnt + 6'h01;
    frame_ok <= link_up && (fcnt == 6'h00);
  end

  gcs_status_map #(.SEC_CYCLES(SEC_CYC)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
    .upd_valid_i(upd_valid), .upd_i(upd), .cfg_valid_i(cfg_valid),
    .cfg_i(cfg), .frame_ok_i(frame_ok), .internal_error_i(int_err),
    .power_loss_i(pwr_loss), .alarm_signal_o(alarm_sig),
    .alarm_relay_o(relay), .fault_relay_closed_o(fault_closed),
    .safe_state_o(safe), .stabilizing_o(stab), .irq_o(irq));

  gcs_poller_model pm (
    .clk_i(clk_i), .pready_i(pready), .prdata_i(prdata),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata));

  task automatic report_and_stop;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic chk1(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask : chk1

  task automatic bus(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd, input logic e_err);
    pm.xfer(wr, idx, wd, rd, err, hung);
    if (hung) begin
      n_errors++;
      report_and_stop();
    end else begin
      chk1("pslverr", e_err, err);
    end
  endtask : bus

  task automatic rdc(input logic [11:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 32'h0, 1'b0);
    chk("rdata", e, rd);
  endtask : rdc

  task automatic send_upd(input logic [8:0] ch, input logic [15:0] v,
                          input logic [15:0] cur, input logic ver);
    @(posedge clk_i);
    upd_valid <= 1'b1;
    upd       <= {ch, v, cur, ver};
    @(posedge clk_i);
    upd_valid <= 1'b0;
  endtask : send_upd

  task automatic cfg_b(input logic [18:0] a, input logic [7:0] d,
                       input logic f, input logic l);
    @(posedge clk_i);
    cfg_valid <= 1'b1;
    cfg       <= {a, d, f, l};
    @(posedge clk_i);
    cfg_valid <= 1'b0;
  endtask : cfg_b

  task automatic settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : settle

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle(4);
    chk1("stabilizing", 1'b1, stab);
    chk1("fault relay", 1'b1, fault_closed);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_i);
      int_err  <= (k == 0);
      pwr_loss <= (k == 1);
      settle(3);
      chk1("fault relay", 1'b0, fault_closed);
      @(posedge clk_i);
      int_err  <= 1'b0;
      pwr_loss <= 1'b0;
      settle(3);
      chk1("fault relay", 1'b1, fault_closed);
    end
    send_upd(9'd0, 16'h0123, 16'h2EE0, 1'b0);
    send_upd(9'd263, 16'h0000, CUR_FAULT_UA, 1'b0);
    send_upd(9'd1, 16'h0001, CUR_FAULT_UA + 16'h0001, 1'b0);
    send_upd(9'd2, 16'h0002, CUR_OVER_UA + 16'h0001, 1'b0);
    send_upd(9'd3, 16'h0003, CUR_OVER_UA, 1'b0);
    send_upd(9'd4, 16'h0004, 16'h2EE0, 1'b1);
    rdc(MEAS_FIRST_IDX, 32'h0000_0123);
    rdc(MEAS_FIRST_IDX + 12'h002, 32'h0000_0002);
    rdc(MEAS_LAST_IDX, 32'h0000_0000);
    rdc(ALARM_FIRST_IDX, 32'h0000_0000);
    rdc(ALARM_LAST_IDX, 32'h0000_0028);
    for (int i = 0; i < 4; i++) begin
      rdc(ALARM_FIRST_IDX + 12'(i + 1), fexp[i]);
    end
    settle(3);
    chk1("fault relay", 1'b0, fault_closed);
    chk1("irq", 1'b0, irq);
    bus(1'b0, IRQ_STAT_IDX, 32'h0, 1'b0);
    chk("irq status", 32'h2, rd & 32'h2);
    bus(1'b0, IRQ_STAT_IDX, 32'h0, 1'b0);
    chk("irq status", 32'h0, rd & 32'h2);
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, THR1_IDX + 12'(k), 32'h100 * (k + 1), 1'b0);
    end
    bus(1'b1, IRQ_MASK_IDX, 32'h1, 1'b0);
    send_upd(9'd5, 16'h0200, 16'h2EE0, 1'b0);
    settle(3);
    chk("relays", 32'h3, {29'h0, relay});
    chk1("alarm", 1'b1, alarm_sig);
    chk1("irq", 1'b1, irq);
    rdc(ALARM_FIRST_IDX + 12'h005, 32'h0000_0003);
    bus(1'b0, IRQ_STAT_IDX, 32'h0, 1'b0);
    chk("irq status", 32'h1, rd & 32'h1);
    settle(2);
    chk1("irq", 1'b0, irq);
    send_upd(9'd5, 16'h0010, 16'h2EE0, 1'b0);
    settle(3);
    chk("relays", 32'h0, {29'h0, relay});
    chk1("alarm", 1'b0, alarm_sig);
    bus(1'b1, MEAS_FIRST_IDX, 32'hFFFF, 1'b1);
    bus(1'b1, CKS_LO_IDX, 32'h0, 1'b1);
    rdc(MEAS_FIRST_IDX, 32'h0000_0123);
    bus(1'b0, 12'h100, 32'h0, 1'b1);
    bus(1'b1, STAB_IDX, 32'h5, 1'b0);
    rdc(STAB_IDX, {23'h0, STAB_MIN_S});
    bus(1'b1, STAB_IDX, 32'h3E8, 1'b0);
    rdc(STAB_IDX, {23'h0, STAB_MAX_S});
    bus(1'b1, STAB_IDX, 32'h1E, 1'b0);
    for (int i = 0; i < 9; i++) begin
      if (i == 4) begin
        cfg_b(RELAY_FIRST, 8'hA5, 1'b0, 1'b0);
        cfg_b(RELAY_LAST, 8'h5A, 1'b0, 1'b0);
      end
      cfg_b(19'(i), 8'h31 + 8'(i), i == 0, i == 8);
    end
    settle(2);
    rdc(CKS_HI_IDX, 32'h0000_CBF4);
    s0 = rd;
    rdc(CKS_LO_IDX, 32'h0000_3926);
    pm.cks_check(32'hCBF4_3926, {s0[15:0], rd[15:0]}, need);
    chk1("reupload", 1'b0, need);
    bus(1'b0, SEC_LO_IDX, 32'h0, 1'b0);
    s0 = rd;
    repeat (400) @(posedge clk_i);
    bus(1'b0, SEC_LO_IDX, 32'h0, 1'b0);
    chk1("seconds", 1'b1, (rd - s0 == 20) || (rd - s0 == 21));
    rdc(SEC_HI_IDX, 32'h0000_0000);
    for (int n = 0; n < 100 && frame_ok !== 1'b1; n++) begin
      @(posedge clk_i);
    end
    if (frame_ok !== 1'b1) begin
      n_errors++;
      report_and_stop();
    end
    link_up <= 1'b0;
    settle(139);
    chk1("safe state", 1'b0, safe);
    settle(30);
    chk1("safe state", 1'b1, safe);
    chk1("stabilizing", 1'b0, stab);
    bus(1'b0, IRQ_STAT_IDX, 32'h0, 1'b0);
    chk("irq status", 32'hC, rd & 32'hC);
    report_and_stop();
  end
endmodule : test_gas_channel_status_map
`default_nettype wire

// [rtl/gcs_pkg.sv]
// gcs_pkg: constants and carriers for the gas channel status map
// assumes a 100 MHz system clock and word-indexed apb register offsets
package gcs_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned SEC_PERIOD_NS  = 1_000_000_000;
  localparam int unsigned SEC_CYCLES_DEF = SEC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned NUM_CH         = 264;

  // register indices; byte address is four times the index
  localparam logic [11:0] MEAS_FIRST_IDX  = 12'h7D1;
  localparam logic [11:0] MEAS_LAST_IDX   = 12'h8D8;
  localparam logic [11:0] ALARM_FIRST_IDX = 12'h8FD;
  localparam logic [11:0] ALARM_LAST_IDX  = 12'hA04;
  localparam logic [11:0] CKS_HI_IDX      = 12'hA28;
  localparam logic [11:0] CKS_LO_IDX      = 12'hA29;
  localparam logic [11:0] SEC_HI_IDX      = 12'hA2A;
  localparam logic [11:0] SEC_LO_IDX      = 12'hA2B;
  localparam logic [11:0] THR1_IDX        = 12'hA30;
  localparam logic [11:0] THR2_IDX        = 12'hA31;
  localparam logic [11:0] THR3_IDX        = 12'hA32;
  localparam logic [11:0] STAB_IDX        = 12'hA33;
  localparam logic [11:0] IRQ_STAT_IDX    = 12'hA34;
  localparam logic [11:0] IRQ_MASK_IDX    = 12'hA35;

  // alarm flag word bit positions
  localparam int unsigned FLG_BELOW   = 3;
  localparam int unsigned FLG_ABOVE   = 4;
  localparam int unsigned FLG_FAULT   = 5;
  localparam int unsigned FLG_RANGE   = 6;
  localparam int unsigned FLG_VERIFY  = 7;

  // input current limits in microamps
  localparam logic [15:0] CUR_FAULT_UA = 16'h0960;
  localparam logic [15:0] CUR_OVER_UA  = 16'h5460;

  // timing in seconds
  localparam logic [3:0]  TX_TIMEOUT_S = 4'h8;
  localparam logic [8:0]  STAB_MIN_S   = 9'h01E;
  localparam logic [8:0]  STAB_MAX_S   = 9'h1F4;
  localparam logic [8:0]  STAB_RST_S   = 9'h01E;

  localparam logic [15:0] THR_RST      = 16'hFFFF;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // interrupt status bits
  localparam int unsigned IRQ_ALARM = 0;
  localparam int unsigned IRQ_FAULT = 1;
  localparam int unsigned IRQ_SAFE  = 2;
  localparam int unsigned IRQ_CRC   = 3;

  localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
  localparam logic [18:0] RELAY_FIRST  = 19'h78000;
  localparam logic [18:0] RELAY_LAST   = 19'h7AFFC;

  typedef struct packed {
    logic [8:0]  chan;
    logic [15:0] value;
    logic [15:0] current_ua;
    logic        verify;
  } gcs_chan_upd_s;

  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  data;
    logic        first;
    logic        last;
  } gcs_cfg_byte_s;

endpackage : gcs_pkg

// [rtl/gcs_status_map.sv]
// gcs_status_map: read-only channel status map on apb, with alarm,
// fault relay, stabilization and link timeout logic
// assumes inputs synchronous to clk_i and one channel update per cycle
//
// Summary of operation
// RULE1: one 16-bit measurement word per channel at indices 2001 to 2264.
// RULE2: poller treats measurements as integers, placing decimals itself.
// RULE3: one 16-bit alarm flag word per channel at indices 2301 to 2564.
// RULE4: bits 0-2 thresholds, 3 below, 4 above, 5 fault, 6 range, 7 verify.
// RULE5: flag bits 8 and up are unused and read zero.
// RULE6: configuration checksum high half at 2600, low half at 2601.
// RULE7: checksum is crc32 of configuration skipping relay area 78000-7AFFC.
// RULE8: poller re-uploads configuration when checksum differs from expected.
// RULE9: seconds counter increments every second, halves at 2602 and 2603.
// RULE10: transmission errors force safe state within eight seconds.
// RULE11: threshold reached raises alarm signal and its relay together.
// RULE12: fault relay opens: internal error, power loss, detector, line fault.
// RULE13: programmable 30 to 500 second stabilization after power-up.
// RULE14: current up to 2.4 mA fault, to 21.6 valid, above over-range.
// RULE15: status words are read-only and reads leave them unchanged.
`timescale 1ns/1ps
`default_nettype none
module gcs_status_map
  import gcs_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF
) (
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          psel_i,
  input  wire logic          penable_i,
  input  wire logic          pwrite_i,
  input  wire logic [15:0]   paddr_i,
  input  wire logic [31:0]   pwdata_i,
  output logic               pready_o,
  output logic [31:0]        prdata_o,
  output logic               pslverr_o,
  input  wire logic          upd_valid_i,
  input  wire gcs_chan_upd_s upd_i,
  input  wire logic          cfg_valid_i,
  input  wire gcs_cfg_byte_s cfg_i,
  input  wire logic          frame_ok_i,
  input  wire logic          internal_error_i,
  input  wire logic          power_loss_i,
  output logic               alarm_signal_o,
  output logic [2:0]         alarm_relay_o,
  output logic               fault_relay_closed_o,
  output logic               safe_state_o,
  output logic               stabilizing_o,
  output logic               irq_o
);

  function automatic logic in_rng(input logic [11:0] idx,
                                  input logic [11:0] lo,
                                  input logic [11:0] hi);
    in_rng = (idx >= lo) && (idx <= hi);
  endfunction : in_rng

  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    crc_byte = r;
  endfunction : crc_byte

  // reset release through two flops
  logic rst_s1_reg, rst_n;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1_reg <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n      <= rst_s1_reg;
    end
  end

  logic [15:0]  meas_mem [NUM_CH];
  logic [7:0]   flag_mem [NUM_CH];
  logic [NUM_CH-1:0] seen_reg;
  logic [15:0]  thr_reg [3];
  logic [8:0]   cnt_reg [4];
  logic [8:0]   cnt_next [4];
  logic [8:0]   stab_reg, stab_s_reg;
  logic [31:0]  pre_reg, sec_reg, crc_reg, cks_reg;
  logic [3:0]   idle_reg, stat_reg, mask_reg, stat_next;
  logic [31:0]  rdata_reg;
  logic         err_reg, safe_reg, fault_open_reg;
  logic [2:0]   relay_reg;

  // seconds prescaler
  wire tick = (pre_reg == SEC_CYCLES - 1);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 32'h00000000;
      sec_reg <= 32'h00000000;
    end else begin
      pre_reg <= tick ? 32'h00000000 : pre_reg + 32'h00000001;
      // RULE9: once-a-second count
      if (tick) sec_reg <= sec_reg + 32'h00000001;
    end
  end

  // channel update and classification
  wire        upd_ok  = upd_valid_i && (upd_i.chan < 9'(NUM_CH));
  wire [8:0]  uch     = upd_i.chan;
  // RULE14: current classes
  wire        cur_low = upd_i.current_ua <= CUR_FAULT_UA;
  wire        cur_hi  = upd_i.current_ua > CUR_OVER_UA;
  wire        cur_ok  = !cur_low && !cur_hi;
  logic [7:0] new_flg;
  logic [7:0] old_flg;
  always_comb begin
    new_flg = 8'h00;
    // RULE4: flag word layout
    for (int k = 0; k < 3; k++) begin
      new_flg[k] = cur_ok && (upd_i.value >= thr_reg[k]);
    end
    new_flg[FLG_BELOW]  = cur_low;
    new_flg[FLG_ABOVE]  = cur_hi;
    new_flg[FLG_FAULT]  = cur_low;
    new_flg[FLG_RANGE]  = cur_hi;
    new_flg[FLG_VERIFY] = upd_i.verify;
    old_flg = seen_reg[uch] ? flag_mem[uch] : 8'h00;
  end

  wire [3:0] new_agg = {new_flg[FLG_FAULT] | new_flg[FLG_RANGE],
                        new_flg[2:0]};
  wire [3:0] old_agg = {old_flg[FLG_FAULT] | old_flg[FLG_RANGE],
                        old_flg[2:0]};
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      cnt_next[k] = cnt_reg[k];
      if (upd_ok && new_agg[k] && !old_agg[k]) begin
        cnt_next[k] = cnt_reg[k] + 9'h001;
      end else if (upd_ok && !new_agg[k] && old_agg[k]) begin
        cnt_next[k] = cnt_reg[k] - 9'h001;
      end
    end
  end

  // tables stay unreset; seen_reg masks stale entries
  always_ff @(posedge clk_i) begin
    // RULE1: measurement stored at its channel slot
    if (upd_ok) meas_mem[uch] <= upd_i.value;
    // RULE3: flag word stored at its channel slot
    if (upd_ok) flag_mem[uch] <= new_flg;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      seen_reg <= '0;
      for (int k = 0; k < 4; k++) cnt_reg[k] <= 9'h000;
    end else begin
      if (upd_ok) seen_reg[uch] <= 1'b1;
      for (int k = 0; k < 4; k++) cnt_reg[k] <= cnt_next[k];
    end
  end

  // relays and alarms
  wire fault_now = internal_error_i || power_loss_i || (cnt_reg[3] != 9'h000);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      relay_reg      <= 3'h0;
      fault_open_reg <= 1'b1;
    end else begin
      // RULE11: relay per threshold
      for (int k = 0; k < 3; k++) relay_reg[k] <= cnt_reg[k] != 9'h000;
      // RULE12: fault relay opens
      fault_open_reg <= fault_now;
    end
  end
  assign alarm_relay_o        = relay_reg;
  // RULE11: signal from the same flops as the relays
  assign alarm_signal_o       = |relay_reg;
  assign fault_relay_closed_o = !fault_open_reg;

  // link timeout and stabilization
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      idle_reg   <= 4'h0;
      safe_reg   <= 1'b0;
      stab_s_reg <= 9'h000;
    end else begin
      // RULE10: seconds without a good frame
      if (frame_ok_i) idle_reg <= 4'h0;
      else if (tick && idle_reg != TX_TIMEOUT_S) idle_reg <= idle_reg + 4'h1;
      safe_reg <= !frame_ok_i && (idle_reg == TX_TIMEOUT_S);
      // RULE13: seconds since power-up, saturating
      if (tick && stab_s_reg != STAB_MAX_S) stab_s_reg <= stab_s_reg + 9'h001;
    end
  end
  assign safe_state_o  = safe_reg;
  assign stabilizing_o = stab_s_reg < stab_reg;

  // RULE7: crc32 over configuration, relay area skipped
  wire        cfg_skip = (cfg_i.addr >= RELAY_FIRST) &&
                         (cfg_i.addr <= RELAY_LAST);
  wire [31:0] crc_base = cfg_i.first ? CRC_INIT : crc_reg;
  wire [31:0] crc_new  = cfg_skip ? crc_base : crc_byte(crc_base, cfg_i.data);
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= CRC_INIT;
      cks_reg <= 32'h00000000;
    end else if (cfg_valid_i) begin
      crc_reg <= crc_new;
      if (cfg_i.last) cks_reg <= ~crc_new;
    end
  end

  // apb decode
  wire [11:0] idx     = paddr_i[13:2];
  wire        setup   = psel_i && !penable_i;
  wire        access  = psel_i && penable_i;
  wire        is_meas = in_rng(idx, MEAS_FIRST_IDX, MEAS_LAST_IDX);
  wire        is_flag = in_rng(idx, ALARM_FIRST_IDX, ALARM_LAST_IDX);
  wire [8:0]  m_ch    = 9'(idx - MEAS_FIRST_IDX);
  wire [8:0]  f_ch    = 9'(idx - ALARM_FIRST_IDX);
  wire        is_rw   = in_rng(idx, THR1_IDX, STAB_IDX) ||
                        (idx == IRQ_MASK_IDX);
  wire        is_ro   = is_meas || is_flag || (idx == IRQ_STAT_IDX) ||
                        in_rng(idx, CKS_HI_IDX, SEC_LO_IDX);
  wire        wr_go   = access && pwrite_i && is_rw;
  // RULE15: writes to status words are refused
  wire        bad     = (pwrite_i && !is_rw) || (!is_rw && !is_ro) ||
                        (paddr_i[1:0] != 2'b00);
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (is_meas) rd_mux = seen_reg[m_ch] ? meas_mem[m_ch] : 16'h0000;
    // RULE5: upper flag bits read zero
    else if (is_flag)
      rd_mux = {8'h00, seen_reg[f_ch] ? flag_mem[f_ch] : 8'h00};
    else begin
      unique case (idx)
        // RULE6: checksum halves
        CKS_HI_IDX:   rd_mux = cks_reg[31:16];
        CKS_LO_IDX:   rd_mux = cks_reg[15:0];
        // RULE9: seconds counter halves
        SEC_HI_IDX:   rd_mux = sec_reg[31:16];
        SEC_LO_IDX:   rd_mux = sec_reg[15:0];
        THR1_IDX:     rd_mux = thr_reg[0];
        THR2_IDX:     rd_mux = thr_reg[1];
        THR3_IDX:     rd_mux = thr_reg[2];
        STAB_IDX:     rd_mux = {7'h00, stab_reg};
        IRQ_STAT_IDX: rd_mux = {12'h000, stat_reg};
        IRQ_MASK_IDX: rd_mux = {12'h000, mask_reg};
        default:      rd_mux = 16'h0000;
      endcase
    end
  end

  // read data captured in setup; a clear only drops the bits that were read,
  // so an event landing between capture and clear survives
  wire       rd_stat = access && !pwrite_i && (idx == IRQ_STAT_IDX);
  wire [3:0] events  = {!safe_reg && !frame_ok_i && idle_reg == TX_TIMEOUT_S,
                        cfg_valid_i && cfg_i.last,
                        fault_now && !fault_open_reg,
                        (|new_agg[2:0]) && upd_ok};
  // status bits: 3 crc done, 2 safe entry, 1 fault opening, 0 threshold
  wire [3:0] ev      = {events[2], events[3], events[1], events[0]};
  assign stat_next = (rd_stat ? (stat_reg & ~rdata_reg[3:0]) : stat_reg) | ev;

  wire [15:0] wd   = pwdata_i[15:0];
  wire [8:0]  st_w = (wd > 16'(STAB_MAX_S)) ? STAB_MAX_S :
                     (wd < 16'(STAB_MIN_S)) ? STAB_MIN_S : wd[8:0];
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
      err_reg   <= 1'b0;
      stat_reg  <= 4'h0;
      mask_reg  <= IRQ_MASK_RST;
      stab_reg  <= STAB_RST_S;
      for (int k = 0; k < 3; k++) thr_reg[k] <= THR_RST;
    end else begin
      if (setup) begin
        rdata_reg <= pwrite_i ? 32'h00000000 : {16'h0000, rd_mux};
        err_reg   <= bad;
      end
      stat_reg <= stat_next;
      if (wr_go && idx == IRQ_MASK_IDX) mask_reg <= pwdata_i[3:0];
      // RULE13: setting clamped to 30..500
      if (wr_go && idx == STAB_IDX) stab_reg <= st_w;
      for (int k = 0; k < 3; k++) begin
        if (wr_go && idx == THR1_IDX + 12'(k)) thr_reg[k] <= wd;
      end
    end
  end
  assign pready_o  = 1'b1;
  assign prdata_o  = rdata_reg;
  assign pslverr_o = access && err_reg;
  assign irq_o     = |(stat_reg & mask_reg);

  ro_write_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE15
    setup && pwrite_i && (is_meas || is_flag) |=> pslverr_o)
    else $error("write to status word not refused");
  sec_step_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE9
    tick |=> sec_reg == $past(sec_reg) + 32'h00000001)
    else $error("seconds counter missed a tick");
  sec_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE9
    !tick |=> $stable(sec_reg))
    else $error("seconds counter moved without tick");
  safe_entry_a: assert property ( // RULE10
    @(posedge clk_i) disable iff (!rst_n)
    tick && idle_reg == 4'h7 && !frame_ok_i ##1 !frame_ok_i |=> safe_state_o)
    else $error("safe state late after link loss");
  relay_follow_a: assert property ( // RULE11
    @(posedge clk_i) disable iff (!rst_n)
    cnt_reg[1] != 9'h000 |=> alarm_relay_o[1] && alarm_signal_o)
    else $error("alarm relay not raised");
  fault_open_a: assert property ( // RULE12
    @(posedge clk_i) disable iff (!rst_n)
    internal_error_i || power_loss_i |=> !fault_relay_closed_o)
    else $error("fault relay stayed closed");
  stab_bound_a: assert property ( // RULE13
    @(posedge clk_i) disable iff (!rst_n)
    stab_reg >= STAB_MIN_S && stab_reg <= STAB_MAX_S)
    else $error("stabilization setting out of bounds");
  over_class_a: assert property ( // RULE14
    @(posedge clk_i) disable iff (!rst_n)
    upd_ok && upd_i.current_ua > CUR_OVER_UA
    |=> flag_mem[$past(uch)][FLG_RANGE] && !flag_mem[$past(uch)][FLG_FAULT])
    else $error("over-range current misclassified");
  flag_high_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE5
    setup && !pwrite_i && is_flag |=> prdata_o[31:8] == 24'h000000)
    else $error("unused flag bits not zero");
  crc_skip_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE7
    cfg_valid_i && cfg_skip && !cfg_i.first |=> crc_reg == $past(crc_reg))
    else $error("relay area entered checksum");
  alarm_irq_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE11
    upd_ok && (|new_agg[2:0]) |=> stat_reg[IRQ_ALARM])
    else $error("threshold event not flagged");
  safe_irq_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE10
    $rose(safe_state_o) |-> stat_reg[IRQ_SAFE])
    else $error("safe state entry not flagged");
  stab_min_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE13
    stab_s_reg < STAB_MIN_S |-> stabilizing_o)
    else $error("stabilization ended too early");
  low_class_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE14
    upd_ok && upd_i.current_ua <= CUR_FAULT_UA
    |=> flag_mem[$past(uch)][FLG_FAULT] && flag_mem[$past(uch)][FLG_BELOW])
    else $error("low current not flagged as fault");
  ch_fault_a: assert property (@(posedge clk_i) disable iff (!rst_n) // RULE12
    cnt_reg[3] != 9'h000 |=> !fault_relay_closed_o)
    else $error("fault relay closed on channel fault");

endmodule : gcs_status_map
`default_nettype wire
